// ===== wdt_pkg.sv
// Constants, field layouts and carrier types for the watchdog block
package wdt_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV       = (TICK_PERIOD_NS * CLK_MHZ) / 1000;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam int DIV_W          = 6;
    localparam int CNT_W          = 21;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTRL_INDEX = 'h21;
    localparam logic [7:0] CTRL_ADDR    = 8'(CTRL_INDEX * 4);
    localparam logic [7:0] RESTART_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR  = 8'h04;
    localparam logic [7:0] CLEAR_ADDR   = 8'h08;
    localparam logic [7:0] IRQ_EN_ADDR  = 8'h0c;
    localparam logic [7:0] COUNT_ADDR   = 8'h10;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int UNLOCK_BIT = 4;
    localparam int ENABLE_BIT = 3;
    localparam int SEL_LSB    = 0;
    localparam int SEL_W      = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_W       = 2;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register fields, bit 4 down to bit 0
    typedef struct packed {
        logic             unlock;
        logic             enable;
        logic [SEL_W-1:0] sel;
    } wdt_ctl_t;
endpackage

// ===== watchdog_timer.sv
// Watchdog timer with timed disable unlock and AXI4-Lite register slave
module watchdog_timer #(
    parameter int unsigned BASE_TICKS = 8192
) (
    // Clock, reset, clock enable
    input  wire logic                         CLK,
    input  wire logic                         NRST,
    input  wire logic                         CE,
    // Write address channel
    input  wire logic                         S_AXI_AWVALID,
    output logic                              S_AXI_AWREADY,
    input  wire logic [wdt_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
    // Write data channel
    input  wire logic                         S_AXI_WVALID,
    output logic                              S_AXI_WREADY,
    input  wire logic [wdt_pkg::DATA_W-1:0]   S_AXI_WDATA,
    input  wire logic [3:0]                   S_AXI_WSTRB,
    // Write response channel
    output logic                              S_AXI_BVALID,
    input  wire logic                         S_AXI_BREADY,
    output logic [1:0]                        S_AXI_BRESP,
    // Read address channel
    input  wire logic                         S_AXI_ARVALID,
    output logic                              S_AXI_ARREADY,
    input  wire logic [wdt_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
    // Read data channel
    output logic                              S_AXI_RVALID,
    input  wire logic                         S_AXI_RREADY,
    output logic [wdt_pkg::DATA_W-1:0]        S_AXI_RDATA,
    output logic [1:0]                        S_AXI_RRESP,
    // Reset request and interrupt
    output logic                              WDT_RESET,
    output logic                              IRQ
);
    import wdt_pkg::*;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Timeout period in ticks for a select code, doubling per step
    function automatic logic [CNT_W-1:0] period_of(
        input logic [SEL_W-1:0] sel);
        period_of = CNT_W'(BASE_TICKS) << sel;
    endfunction

    // Known register addresses answer OKAY, the rest SLVERR
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = (a == CTRL_ADDR) || (a == RESTART_ADDR) ||
                     (a == STATUS_ADDR) || (a == CLEAR_ADDR) ||
                     (a == IRQ_EN_ADDR) || (a == COUNT_ADDR);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    wdt_ctl_t          ctl_reg,      ctl_next;
    logic [2:0]        unl_cnt_reg,  unl_cnt_next;
    logic [DIV_W-1:0]  div_reg,      div_next;
    logic              tick_reg,     tick_next;
    logic [CNT_W-1:0]  count_reg,    count_next;
    logic              rst_req_reg,  rst_req_next;
    logic [ST_W-1:0]   status_reg,   status_next;
    logic [ST_W-1:0]   irq_en_reg,   irq_en_next;
    logic              irq_reg,      irq_next;
    logic              awready_reg,  awready_next;
    logic              bvalid_reg,   bvalid_next;
    logic [1:0]        bresp_reg,    bresp_next;
    logic              arready_reg,  arready_next;
    logic              rvalid_reg,   rvalid_next;
    logic [DATA_W-1:0] rdata_reg,    rdata_next;
    logic [1:0]        rresp_reg,    rresp_next;

    logic              wr_go;
    logic              rd_go;
    logic              ctl_wr;
    logic              restart_wr;
    logic              fire;
    wdt_ctl_t          wr_ctl;
    logic [ST_W-1:0]   st_set;
    logic [ST_W-1:0]   st_clr;

    // ------------------------------------------------------------
    // Bus request decode
    // ------------------------------------------------------------
    // Write taken when address and data both wait and no response pends
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !awready_reg &&
                   !bvalid_reg;
    assign rd_go = S_AXI_ARVALID && !arready_reg && !rvalid_reg;
    assign ctl_wr = wr_go && (S_AXI_AWADDR == CTRL_ADDR) &&
                    S_AXI_WSTRB[0];
    assign restart_wr = wr_go && (S_AXI_AWADDR == RESTART_ADDR);
    // Bits 7..5 of the written byte are dropped here
    assign wr_ctl = wdt_ctl_t'(S_AXI_WDATA[UNLOCK_BIT:SEL_LSB]);
    assign fire = ctl_reg.enable && tick_reg &&
                  (count_reg >= period_of(ctl_reg.sel) - CNT_W'(1));

    // ------------------------------------------------------------
    // Control register and unlock window
    // ------------------------------------------------------------
    // Next control value: enable sets freely, clears only when unlocked
    always_comb begin
        ctl_next     = ctl_reg;
        unl_cnt_next = unl_cnt_reg;
        st_set       = '0;
        if (ctl_reg.unlock) begin
            unl_cnt_next = unl_cnt_reg - 3'h1;
            if (unl_cnt_reg == 3'h1) begin
                ctl_next.unlock = 1'b0;
            end
        end
        if (ctl_wr) begin
            ctl_next.sel = wr_ctl.sel;
            if (wr_ctl.enable) begin
                ctl_next.enable = 1'b1;
            end else if (ctl_reg.unlock) begin
                ctl_next.enable = 1'b0;
            end else if (ctl_reg.enable) begin
                st_set[ST_REFUSED] = 1'b1;
            end
            if (wr_ctl.unlock) begin
                ctl_next.unlock = 1'b1;
                unl_cnt_next    = UNLOCK_CYCLES;
            end
        end
        if (fire) begin
            st_set[ST_TIMEOUT] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Tick divider and watchdog counter
    // ------------------------------------------------------------
    // Tick every TICK_DIV clocks regardless of the select code
    always_comb begin
        tick_next = 1'b0;
        div_next  = div_reg + DIV_W'(1);
        if (div_reg == DIV_W'(TICK_DIV - 1)) begin
            div_next  = '0;
            tick_next = 1'b1;
        end
        count_next   = count_reg;
        rst_req_next = 1'b0;
        if (restart_wr) begin
            count_next = '0;
        end else if (fire) begin
            count_next   = '0;
            rst_req_next = 1'b1;
        end else if (ctl_reg.enable && tick_reg) begin
            count_next = count_reg + CNT_W'(1);
        end
        // Disabled counter keeps its value for a later enable unless a restart write clears it
    end

    // ------------------------------------------------------------
    // Status, interrupt enable, interrupt line
    // ------------------------------------------------------------
    // Sticky status: a setting event wins over a clear in the same cycle
    always_comb begin
        st_clr      = '0;
        irq_en_next = irq_en_reg;
        if (wr_go && S_AXI_WSTRB[0]) begin
            if (S_AXI_AWADDR == CLEAR_ADDR) begin
                st_clr = S_AXI_WDATA[ST_W-1:0];
            end
            if (S_AXI_AWADDR == IRQ_EN_ADDR) begin
                irq_en_next = S_AXI_WDATA[ST_W-1:0];
            end
        end
        status_next = (status_reg & ~st_clr) | st_set;
        irq_next    = |(status_next & irq_en_next);
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes and read data
    // ------------------------------------------------------------
    // One-cycle ready pulses, response held until the master takes it
    always_comb begin
        awready_next = wr_go;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next  = addr_known(S_AXI_AWADDR) ? RESP_OKAY
                                                   : RESP_SLVERR;
        end
        arready_next = rd_go;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = addr_known(S_AXI_ARADDR) ? RESP_OKAY
                                                   : RESP_SLVERR;
            case (S_AXI_ARADDR)
                CTRL_ADDR:   rdata_next = DATA_W'(ctl_reg);
                STATUS_ADDR: rdata_next = DATA_W'(status_reg);
                IRQ_EN_ADDR: rdata_next = DATA_W'(irq_en_reg);
                COUNT_ADDR:  rdata_next = DATA_W'(count_reg);
                default:     rdata_next = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All state holds while CE is low
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctl_reg     <= wdt_ctl_t'(CTRL_RESET[UNLOCK_BIT:SEL_LSB]);
            unl_cnt_reg <= '0;
            div_reg     <= '0;
            tick_reg    <= 1'b0;
            count_reg   <= '0;
            rst_req_reg <= 1'b0;
            status_reg  <= STATUS_RESET;
            irq_en_reg  <= STATUS_RESET;
            irq_reg     <= 1'b0;
            awready_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (CE) begin
            ctl_reg     <= ctl_next;
            unl_cnt_reg <= unl_cnt_next;
            div_reg     <= div_next;
            tick_reg    <= tick_next;
            count_reg   <= count_next;
            rst_req_reg <= rst_req_next;
            status_reg  <= status_next;
            irq_en_reg  <= irq_en_next;
            irq_reg     <= irq_next;
            awready_reg <= awready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // Outputs straight from flip-flops
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY  = awready_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign WDT_RESET     = rst_req_reg;
    assign IRQ           = irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    // Unlocking write followed by four quiet enabled cycles
    sequence unlock_write_s;
        CE && ctl_wr && wr_ctl.unlock;
    endsequence
    sequence quiet_four_s;
        (CE && !ctl_wr)[*4];
    endsequence

    unlock_expiry_a: assert property (
        unlock_write_s ##1 quiet_four_s |=> !ctl_reg.unlock)
        else $error("unlock bit did not clear after four cycles");

    unlock_window_a: assert property (
        unlock_write_s ##1 (CE && !ctl_wr)[*3] |=> ctl_reg.unlock)
        else $error("unlock bit cleared too early");

    refuse_disable_a: assert property (
        CE && ctl_wr && !wr_ctl.enable && !ctl_reg.unlock &&
        ctl_reg.enable |=> ctl_reg.enable && status_reg[ST_REFUSED])
        else $error("disable accepted without unlock");

    allow_disable_a: assert property (
        CE && ctl_wr && !wr_ctl.enable && ctl_reg.unlock
        |=> !ctl_reg.enable)
        else $error("unlocked disable not taken");

    enable_write_a: assert property (
        CE && ctl_wr && wr_ctl.enable |=> ctl_reg.enable)
        else $error("enable write not taken");

    reset_pulse_a: assert property (
        WDT_RESET && CE |=> !WDT_RESET)
        else $error("reset request longer than one cycle");

    restart_clear_a: assert property (
        CE && restart_wr |=> count_reg == '0)
        else $error("restart did not clear counter");

    timeout_fire_a: assert property (
        CE && !restart_wr && ctl_reg.enable && tick_reg &&
        count_reg == period_of(ctl_reg.sel) - CNT_W'(1)
        |=> WDT_RESET && count_reg == '0 && status_reg[ST_TIMEOUT])
        else $error("timeout did not request reset");

    period_code_a: assert property (
        period_of(3'h0) == CNT_W'(BASE_TICKS) &&
        period_of(3'h1) == CNT_W'(BASE_TICKS) * CNT_W'(2) &&
        period_of(3'h4) == CNT_W'(BASE_TICKS) * CNT_W'(16) &&
        period_of(3'h7) == CNT_W'(BASE_TICKS) * CNT_W'(128))
        else $error("period decode wrong");

    tick_phase_a: assert property (
        tick_reg |-> div_reg == '0)
        else $error("tick out of phase with divider");

    residual_hold_a: assert property (
        CE && !ctl_reg.enable && !restart_wr |=> $stable(count_reg))
        else $error("disabled counter changed");

    reserved_read_a: assert property (
        CE && rd_go && S_AXI_ARADDR == CTRL_ADDR
        |=> rvalid_reg && rdata_reg[7:5] == 3'h0)
        else $error("reserved control bits read nonzero");

    // A status bit stays set until software clears it
    status_sticky_a: assert property (
        CE && !(wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == CLEAR_ADDR))
        |=> (status_reg & $past(status_reg)) == $past(status_reg))
        else $error("status bit lost without a clear");

    // Interrupt line is high while an enabled status bit is set
    irq_level_a: assert property (
        CE |=> IRQ == |(status_reg & irq_en_reg))
        else $error("interrupt line does not follow status");

endmodule // watchdog_timer

// ===== watchdog_timer_with_safe_disable_bench.sv
// Self-checking bench for the watchdog timer with timed disable unlock
module watchdog_timer_with_safe_disable_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    // ------------------------------------------------------------
    // Signals and settings
    // ------------------------------------------------------------
    localparam int BT = 16;                // Short base period for simulation
    localparam int TK = TICK_DIV;          // Clocks per watchdog tick
    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [1:0]  resp;
    } row_t;
    logic               CLK;
    logic               NRST;
    logic               CE;
    logic               S_AXI_AWVALID;
    logic               S_AXI_AWREADY;
    logic [ADDR_W-1:0]  S_AXI_AWADDR;
    logic               S_AXI_WVALID;
    logic               S_AXI_WREADY;
    logic [DATA_W-1:0]  S_AXI_WDATA;
    logic [3:0]         S_AXI_WSTRB;
    logic               S_AXI_BVALID;
    logic               S_AXI_BREADY;
    logic [1:0]         S_AXI_BRESP;
    logic               S_AXI_ARVALID;
    logic               S_AXI_ARREADY;
    logic [ADDR_W-1:0]  S_AXI_ARADDR;
    logic               S_AXI_RVALID;
    logic               S_AXI_RREADY;
    logic [DATA_W-1:0]  S_AXI_RDATA;
    logic [1:0]         S_AXI_RRESP;
    logic               WDT_RESET;
    logic               IRQ;
    int                 fail_count;
    int                 checks_done;
    row_t               rows [9];
    logic [1:0]         rsp;
    logic [31:0]        rd;
    logic [31:0]        cnt;
    logic [31:0]        fired;
    int                 cyc;
    int                 p;

    watchdog_timer #(.BASE_TICKS(BT)) u_dut (
        .CLK(CLK), .NRST(NRST), .CE(CE),
        .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .WDT_RESET(WDT_RESET), .IRQ(IRQ)
    );

    // Free-running 50 MHz clock
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic give_verdict;
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Compare and count
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // One write; address and data offered together, held until taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int n;
        @(posedge CLK);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (S_AXI_BVALID !== 1'b1 && n < 200);
        r = S_AXI_BRESP;
        @(posedge CLK);
        S_AXI_AWVALID <= 1'b0;
        S_AXI_WVALID  <= 1'b0;
        S_AXI_BREADY  <= 1'b0;
        if (n >= 200) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // One read, held until the answer comes
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        @(posedge CLK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (S_AXI_RVALID !== 1'b1 && n < 200);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        @(posedge CLK);
        S_AXI_ARVALID <= 1'b0;
        S_AXI_RREADY  <= 1'b0;
        if (n >= 200) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // Count cycles until the reset request, bounded
    task automatic wait_fire(input int lim, output int c);
        c = 0;
        while (WDT_RESET !== 1'b1 && c < lim) begin
            @(negedge CLK);
            c++;
        end
    endtask

    // Watch for any reset request over a span of cycles
    task automatic quiet(input int span, output logic [31:0] f);
        f = 32'h0;
        repeat (span) begin
            @(negedge CLK);
            if (WDT_RESET !== 1'b0) f = 32'h1;
        end
    endtask

    // Synchronous reset held for 8 cycles
    task automatic do_reset;
        @(posedge CLK);
        NRST <= 1'b0;
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        checks_done = 0;
        NRST = 1'b0; CE = 1'b1;
        S_AXI_AWVALID = 1'b0; S_AXI_AWADDR = 8'h00; S_AXI_WVALID = 1'b0;
        S_AXI_WDATA = 32'h0; S_AXI_WSTRB = 4'hf; S_AXI_BREADY = 1'b0;
        S_AXI_ARVALID = 1'b0; S_AXI_ARADDR = 8'h00; S_AXI_RREADY = 1'b0;
        rows = '{'{1'b0, CTRL_ADDR, 32'h0, RESP_OKAY},
                 '{1'b1, CTRL_ADDR, 32'hffff_ffe5, RESP_OKAY},
                 '{1'b0, CTRL_ADDR, 32'h5, RESP_OKAY},
                 '{1'b0, STATUS_ADDR, 32'h0, RESP_OKAY},
                 '{1'b0, RESTART_ADDR, 32'h0, RESP_OKAY},
                 '{1'b1, 8'h40, 32'h1f, RESP_SLVERR},
                 '{1'b0, 8'h40, 32'h0, RESP_SLVERR},
                 '{1'b1, IRQ_EN_ADDR, 32'h0, RESP_OKAY},
                 '{1'b0, IRQ_EN_ADDR, 32'h0, RESP_OKAY}};
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        // Table of plain register accesses
        for (int i = 0; i < 9; i++) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, rsp);
            end else begin
                axi_read(rows[i].addr, rd, rsp);
                check("rdata", rows[i].data, rd);
            end
            check("resp", 32'(rows[i].resp), 32'(rsp));
        end
        // Timeout length for the first four select codes
        for (int c = 0; c < 4; c++) begin
            p = BT << c;
            axi_write(RESTART_ADDR, 32'h0, rsp);
            axi_write(CTRL_ADDR, 32'h8 | c, rsp);
            axi_write(RESTART_ADDR, 32'h0, rsp);
            wait_fire(p * TK + 20, cyc);
            check("timeout early", 32'h0, 32'(cyc < (p - 1) * TK));
            check("timeout late", 32'h0, 32'(cyc > p * TK + 10));
            @(negedge CLK);
            check("reset width", 32'h0, {31'h0, WDT_RESET});
        end
        // Sticky timeout status, interrupt mask and clear
        check("irq masked", 32'h0, {31'h0, IRQ});
        axi_read(STATUS_ADDR, rd, rsp);
        check("status timeout", 32'h1, rd & 32'h1);
        axi_write(IRQ_EN_ADDR, 32'h1, rsp);
        @(negedge CLK);
        check("irq raised", 32'h1, {31'h0, IRQ});
        axi_write(CLEAR_ADDR, 32'h3, rsp);
        @(negedge CLK);
        check("irq cleared", 32'h0, {31'h0, IRQ});
        // Regular restarts keep the shortest period from expiring
        axi_write(RESTART_ADDR, 32'h0, rsp);
        axi_write(CTRL_ADDR, 32'h8, rsp);
        repeat (4) begin
            quiet(600, fired);
            axi_write(RESTART_ADDR, 32'h0, rsp);
            check("restart holds off", 32'h0, fired);
        end
        // Disable without unlock is refused and flagged
        axi_write(CTRL_ADDR, 32'h0, rsp);
        axi_read(CTRL_ADDR, rd, rsp);
        check("ctrl after refusal", 32'h8, rd);
        axi_read(STATUS_ADDR, rd, rsp);
        check("status refused", 32'h2, rd & 32'h2);
        // Unlock seen inside its window, gone after it
        axi_write(RESTART_ADDR, 32'h0, rsp);
        axi_write(CTRL_ADDR, 32'h18, rsp);
        axi_read(CTRL_ADDR, rd, rsp);
        check("unlock set", 32'h18, rd);
        repeat (10) @(negedge CLK);
        axi_read(CTRL_ADDR, rd, rsp);
        check("unlock cleared", 32'h8, rd);
        axi_write(CTRL_ADDR, 32'h0, rsp);
        axi_read(CTRL_ADDR, rd, rsp);
        check("late disable", 32'h8, rd);
        // Proper two-write disable; counter then holds its value
        repeat (300) @(negedge CLK);
        axi_write(CTRL_ADDR, 32'h18, rsp);
        axi_write(CTRL_ADDR, 32'h0, rsp);
        axi_read(CTRL_ADDR, rd, rsp);
        check("disabled", 32'h0, rd);
        axi_read(COUNT_ADDR, cnt, rsp);
        quiet(1000, fired);
        check("no timeout disabled", 32'h0, fired);
        axi_read(COUNT_ADDR, rd, rsp);
        check("count held", cnt, rd);
        // Enable without restart resumes from the residual count
        axi_write(CTRL_ADDR, 32'h8, rsp);
        wait_fire(BT * TK + 20, cyc);
        check("residual short", 32'h0,
              32'(cyc > (BT - int'(cnt)) * TK + 10));
        // Clock enable low freezes the watchdog past its shortest period
        @(posedge CLK);
        CE <= 1'b0;
        quiet(1000, fired);
        @(posedge CLK);
        CE <= 1'b1;
        check("frozen no timeout", 32'h0, fired);
        // Reset in mid-run returns the control register to zero
        do_reset();
        axi_read(CTRL_ADDR, rd, rsp);
        check("ctrl after reset", 32'(CTRL_RESET), rd);
        axi_read(COUNT_ADDR, rd, rsp);
        check("count after reset", 32'h0, rd);
        give_verdict();
    end
endmodule // watchdog_timer_with_safe_disable_bench
